/* File: verilog/uart_shadow_data_port.sv */
`timescale 1ns/1ps
module uart_shadow_data_port (
	input  wire logic                               clk,
	input  wire logic                               nrst,
	input  wire logic                               ce,
	// ahb-lite slave
	input  wire logic                               hsel,
	input  wire logic [31:0]                        haddr,
	input  wire logic [1:0]                         htrans,
	input  wire logic                               hwrite,
	input  wire logic [2:0]                         hsize,
	input  wire logic [uart_shadow_pkg::DATA_W-1:0] hwdata,
	input  wire logic                               hready,
	output logic                                    hreadyout,
	output logic                                    hresp,
	output logic [uart_shadow_pkg::DATA_W-1:0]      hrdata,
	// receive characters from the deserializers
	input  wire logic                               rxSerialValid,
	input  wire logic [uart_shadow_pkg::CHAR_W-1:0] rxSerialChar,
	input  wire logic                               rxInfraValid,
	input  wire logic [uart_shadow_pkg::CHAR_W-1:0] rxInfraChar,
	// transmit characters to the serializer
	output logic                                    txAvail,
	output logic [uart_shadow_pkg::CHAR_W-1:0]      txChar,
	input  wire logic                               txTake,
	output logic                                    txInfraSel,
	// flags for line status and interrupt logic
	output logic                                    dataReadyFlag,
	output logic                                    overrunFlag,
	output logic                                    txHoldingEmpty,
	output logic                                    fifoEnable,
	output logic                                    irq
);
	import uart_shadow_pkg::*;

	busState_t         busState_q;
	logic [31:0]       addr_q;
	logic [DATA_W-1:0] hrdata_q;
	logic [DATA_W-1:0] rdValue;
	logic              addrPhase;
	logic [31:0]       slotOff;
	logic              isSlot;
	logic              readDone;
	logic              writeNow;

	logic              fifoMode_q;
	logic              infraMode_q;
	logic [IRQ_W-1:0]  irqStatus_q;
	logic [IRQ_W-1:0]  irqMask_q;
	logic [IRQ_W-1:0]  events;

	logic              rxInValid;
	logic [CHAR_W-1:0] rxInChar;
	logic [CHAR_W-1:0] rxBuf_q;
	logic              rxBufFull_q;
	logic              rxFifoInReady;
	logic              rxFifoOutValid;
	logic [CHAR_W-1:0] rxFifoHead;
	logic              rxPop;
	logic              rxFlush;
	logic              rxStored;
	logic              overrunEvent;
	logic              overrun_q;

	logic [CHAR_W-1:0] txHold_q;
	logic              txHoldEmpty_q;
	logic              txFifoInReady;
	logic              txFifoOutValid;
	logic [CHAR_W-1:0] txFifoHead;
	logic              txFlush;
	logic              slotWrite;
	logic              txDrop;
	logic              txEmpty;
	logic              txEmptyPrev_q;
	logic              fifoCtrlWrite;

	// bus decode
	assign addrPhase = hsel & htrans[1] & hready;
	assign slotOff   = addr_q - SLOT_BASE;
	assign isSlot    = (slotOff < SLOT_SPAN) && (slotOff[1:0] == 2'b00);
	assign readDone  = ce && (busState_q == BUS_READ);
	assign writeNow  = ce && (busState_q == BUS_WRITE);

	// reads take one wait state so that hrdata comes from a flip-flop
	assign hreadyout = (busState_q != BUS_READ);
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busState_q <= BUS_IDLE;
			addr_q     <= '0;
		end else if (ce) begin
			unique case (busState_q)
				BUS_READ: begin
					busState_q <= BUS_READ_DONE;
				end
				BUS_IDLE, BUS_WRITE, BUS_READ_DONE: begin
					if (addrPhase) begin
						busState_q <= hwrite ? BUS_WRITE : BUS_READ;
						addr_q     <= haddr;
					end else begin
						busState_q <= BUS_IDLE;
					end
				end
			endcase
		end
	end

	// read mux, unmapped addresses read zero
	always_comb begin
		rdValue = '0;
		if (isSlot) begin
			rdValue[CHAR_W-1:0] = fifoMode_q ? rxFifoHead : rxBuf_q;
		end else begin
			unique case (addr_q)
				LINE_STATUS_ADDR: begin
					rdValue[LS_DATA_READY] = dataReadyFlag;
					rdValue[LS_OVERRUN]    = overrun_q;
					rdValue[LS_TX_EMPTY]   = txEmpty;
					rdValue[LS_TX_IDLE]    = txEmpty;
				end
				FIFO_CTRL_ADDR: begin
					rdValue[FC_ENABLE] = fifoMode_q;
				end
				MODE_CTRL_ADDR: begin
					rdValue[MC_INFRARED] = infraMode_q;
				end
				IRQ_STATUS_ADDR: begin
					rdValue[IRQ_W-1:0] = irqStatus_q;
				end
				IRQ_MASK_ADDR: begin
					rdValue[IRQ_W-1:0] = irqMask_q;
				end
				default: begin
					rdValue = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hrdata_q <= '0;
		end else if (readDone) begin
			hrdata_q <= rdValue;
		end
	end

	// control registers
	assign fifoCtrlWrite = writeNow && (addr_q == FIFO_CTRL_ADDR);
	// a mode change empties both paths so no stale character crosses over
	assign rxFlush = fifoCtrlWrite && (hwdata[FC_RX_FLUSH] || (hwdata[FC_ENABLE] != fifoMode_q));
	assign txFlush = fifoCtrlWrite && (hwdata[FC_TX_FLUSH] || (hwdata[FC_ENABLE] != fifoMode_q));

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fifoMode_q  <= 1'b0;
			infraMode_q <= 1'b0;
			irqMask_q   <= IRQ_RESET;
		end else if (writeNow) begin
			if (addr_q == FIFO_CTRL_ADDR) begin
				fifoMode_q <= hwdata[FC_ENABLE];
			end
			if (addr_q == MODE_CTRL_ADDR) begin
				infraMode_q <= hwdata[MC_INFRARED];
			end
			if (addr_q == IRQ_MASK_ADDR) begin
				irqMask_q <= hwdata[IRQ_W-1:0];
			end
		end
	end

	assign fifoEnable = fifoMode_q;
	assign txInfraSel = infraMode_q;

	// receive path
	// input select follows the mode
	assign rxInValid = infraMode_q ? rxInfraValid : rxSerialValid;
	assign rxInChar  = infraMode_q ? rxInfraChar : rxSerialChar;
	assign dataReadyFlag = fifoMode_q ? rxFifoOutValid : rxBufFull_q;
	assign rxPop = readDone && isSlot && dataReadyFlag;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rxBuf_q     <= CHAR_RESET;
			rxBufFull_q <= 1'b0;
		end else if (ce) begin
			if (rxFlush) begin
				rxBufFull_q <= 1'b0;
			end else if (rxInValid && !fifoMode_q) begin
				rxBuf_q     <= rxInChar;
				rxBufFull_q <= 1'b1;
			end else if (rxPop && !fifoMode_q) begin
				rxBufFull_q <= 1'b0;
			end
		end
	end

	// fifo head feeds the slot read
	uart_char_fifo #(
		.WIDTH (CHAR_W),
		.DEPTH (FIFO_DEPTH)
	) rxFifo (
		.clk      (clk),
		.nrst     (nrst),
		.ce       (ce),
		.flush    (rxFlush),
		.inValid  (rxInValid && fifoMode_q && !rxFlush),
		.inData   (rxInChar),
		.inReady  (rxFifoInReady),
		.outValid (rxFifoOutValid),
		.outData  (rxFifoHead),
		.outReady (rxPop && fifoMode_q)
	);

	assign overrunEvent = rxInValid && !rxFlush &&
		(fifoMode_q ? !rxFifoInReady : (rxBufFull_q && !rxPop));
	assign rxStored = rxInValid && !rxFlush && (!fifoMode_q || rxFifoInReady);

	// overrun clears on a line status read, a new overrun in that cycle wins
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			overrun_q <= 1'b0;
		end else if (ce) begin
			if (overrunEvent) begin
				overrun_q <= 1'b1;
			end else if (readDone && (addr_q == LINE_STATUS_ADDR)) begin
				overrun_q <= 1'b0;
			end
		end
	end

	assign overrunFlag = overrun_q;

	// transmit path
	// a write to any slot loads a character, except into a full transmit fifo
	assign slotWrite = writeNow && isSlot;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			txHold_q      <= CHAR_RESET;
			txHoldEmpty_q <= 1'b1;
		end else if (ce) begin
			if (txFlush) begin
				txHoldEmpty_q <= 1'b1;
			end else if (slotWrite && !fifoMode_q) begin
				// later writes overwrite the pending one
				txHold_q      <= hwdata[CHAR_W-1:0];
				txHoldEmpty_q <= 1'b0;
			end else if (txTake && !txHoldEmpty_q && !fifoMode_q) begin
				txHoldEmpty_q <= 1'b1;
			end
		end
	end

	uart_char_fifo #(
		.WIDTH (CHAR_W),
		.DEPTH (FIFO_DEPTH)
	) txFifo (
		.clk      (clk),
		.nrst     (nrst),
		.ce       (ce),
		.flush    (txFlush),
		.inValid  (slotWrite && fifoMode_q && !txFlush),
		.inData   (hwdata[CHAR_W-1:0]),
		.inReady  (txFifoInReady),
		.outValid (txFifoOutValid),
		.outData  (txFifoHead),
		.outReady (txTake && fifoMode_q)
	);

	assign txDrop = slotWrite && fifoMode_q && !txFifoInReady;

	assign txEmpty        = fifoMode_q ? !txFifoOutValid : txHoldEmpty_q;
	assign txHoldingEmpty = txEmpty;
	assign txAvail        = !txEmpty;
	assign txChar         = fifoMode_q ? txFifoHead : txHold_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			txEmptyPrev_q <= 1'b1;
		end else if (ce) begin
			txEmptyPrev_q <= txEmpty;
		end
	end

	// interrupts: sticky, cleared by reading status, a new event wins
	always_comb begin
		events              = '0;
		events[EV_RX_CHAR]  = rxStored;
		events[EV_OVERRUN]  = overrunEvent;
		events[EV_TX_EMPTY] = txEmpty && !txEmptyPrev_q;
		events[EV_TX_DROP]  = txDrop;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irqStatus_q <= IRQ_RESET;
		end else if (ce) begin
			if (readDone && (addr_q == IRQ_STATUS_ADDR)) begin
				irqStatus_q <= events;
			end else begin
				irqStatus_q <= irqStatus_q | events;
			end
		end
	end

	assign irq = |(irqStatus_q & irqMask_q);
endmodule

/* File: verilog/uart_shadow_pkg.sv */
// How it works
// - sixteen consecutive word slots all alias the one receive buffer and transmit holding path.
// - a slot read returns the received character in bits 7:0, from serial or infrared input.
// - received data is valid only while the data-ready flag is set.
// - with fifos off, a new character overwrites an unread one and raises overrun.
// - with fifos on, a slot read returns and removes the head of the receive fifo.
// - with the receive fifo full, an arriving character is dropped and overrun is raised.
// - a slot write loads a character for the serial or active-low infrared output.
// - with fifos off and holding-empty set, one write clears holding-empty.
// - with fifos off, further writes before holding-empty returns overwrite the pending one.
// - with fifos on, up to the fifo depth of characters are accepted before full.
// - a write while the transmit fifo is full is discarded and the fifo is unchanged.
package uart_shadow_pkg;
	localparam int unsigned DATA_W     = 32;
	localparam int unsigned CHAR_W     = 8;
	localparam int unsigned FIFO_DEPTH = 16;
	localparam int unsigned SLOT_COUNT = 16;

	localparam logic [31:0] SLOT_BASE   = 32'h5000_1130;
	localparam logic [31:0] SLOT7_ADDR  = 32'h5000_114c;
	localparam logic [31:0] SLOT8_ADDR  = 32'h5000_1150;
	localparam logic [31:0] SLOT_SPAN   = 32'h0000_0040;
	localparam logic [31:0] LINE_STATUS_ADDR = 32'h5000_1174;
	localparam logic [31:0] FIFO_CTRL_ADDR   = 32'h5000_1178;
	localparam logic [31:0] MODE_CTRL_ADDR   = 32'h5000_117c;
	localparam logic [31:0] IRQ_STATUS_ADDR  = 32'h5000_1180;
	localparam logic [31:0] IRQ_MASK_ADDR    = 32'h5000_1184;

	// line status fields
	localparam int unsigned LS_DATA_READY = 0;
	localparam int unsigned LS_OVERRUN    = 1;
	localparam int unsigned LS_TX_EMPTY   = 5;
	localparam int unsigned LS_TX_IDLE    = 6;
	// fifo control fields
	localparam int unsigned FC_ENABLE   = 0;
	localparam int unsigned FC_RX_FLUSH = 1;
	localparam int unsigned FC_TX_FLUSH = 2;
	// mode control fields
	localparam int unsigned MC_INFRARED = 0;
	// interrupt event fields
	localparam int unsigned IRQ_W       = 4;
	localparam int unsigned EV_RX_CHAR  = 0;
	localparam int unsigned EV_OVERRUN  = 1;
	localparam int unsigned EV_TX_EMPTY = 2;
	localparam int unsigned EV_TX_DROP  = 3;

	localparam logic [CHAR_W-1:0] CHAR_RESET  = 8'h00;
	localparam logic [IRQ_W-1:0]  IRQ_RESET   = 4'h0;

	typedef enum logic [1:0] {
		BUS_IDLE      = 2'b00,
		BUS_READ      = 2'b01,
		BUS_READ_DONE = 2'b11,
		BUS_WRITE     = 2'b10
	} busState_t;
endpackage

/* File: verilog/uart_char_fifo.sv */
`timescale 1ns/1ps
module uart_char_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             ce,
	input  wire logic             flush,
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  inReady,
	output logic                  outValid,
	output logic [WIDTH-1:0]      outData,
	input  wire logic             outReady
);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_COUNT = DEPTH[AW:0];

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_q;
	logic [AW-1:0]    rdPtr_q;
	logic [AW:0]      count_q;
	logic             push;
	logic             pop;

	// a push while full is simply not taken, contents stay intact
	assign inReady  = (count_q != FULL_COUNT);
	assign outValid = (count_q != '0);
	assign outData  = mem[rdPtr_q];
	assign push     = inValid & inReady;
	assign pop      = outValid & outReady;

	always_ff @(posedge clk) begin
		if (ce && push) begin
			mem[wrPtr_q] <= inData;
		end
	end

	// pointers wrap by overflow, so depth must be a power of two
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else if (ce) begin
			if (flush) begin
				wrPtr_q <= '0;
				rdPtr_q <= '0;
				count_q <= '0;
			end else begin
				if (push) begin
					wrPtr_q <= wrPtr_q + 1'b1;
				end
				if (pop) begin
					rdPtr_q <= rdPtr_q + 1'b1;
				end
				if (push && !pop) begin
					count_q <= count_q + 1'b1;
				end else if (pop && !push) begin
					count_q <= count_q - 1'b1;
				end
			end
		end
	end
endmodule

/* File: sim/uart_shadow_data_port_sva.sv */
`timescale 1ns/1ps
module uart_shadow_data_port_sva (
	input wire logic                               clk,
	input wire logic                               nrst,
	input wire logic                               ce,
	input wire logic                               hsel,
	input wire logic [31:0]                        haddr,
	input wire logic [1:0]                         htrans,
	input wire logic                               hwrite,
	input wire logic [uart_shadow_pkg::DATA_W-1:0] hwdata,
	input wire logic                               hready,
	input wire logic                               hreadyout,
	input wire logic [uart_shadow_pkg::DATA_W-1:0] hrdata,
	input wire logic                               rxSerialValid,
	input wire logic                               rxInfraValid,
	input wire logic                               txAvail,
	input wire logic [uart_shadow_pkg::CHAR_W-1:0] txChar,
	input wire logic                               txTake,
	input wire logic                               txInfraSel,
	input wire logic                               dataReadyFlag,
	input wire logic                               overrunFlag,
	input wire logic                               txHoldingEmpty,
	input wire logic                               fifoEnable
);
	import uart_shadow_pkg::*;
	logic taken, arrive, slotWr, rdPh_q, wrPh_q, slotPh_q;
	assign taken  = ce && hsel && htrans[1] && hready;
	assign arrive = ce && (txInfraSel ? rxInfraValid : rxSerialValid);
	// a take on the same edge would make the expected holding value ambiguous
	assign slotWr = ce && hready && wrPh_q && slotPh_q && !txTake;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdPh_q   <= 1'b0;
			wrPh_q   <= 1'b0;
			slotPh_q <= 1'b0;
		end else if (ce && hready) begin
			rdPh_q   <= taken && !hwrite;
			wrPh_q   <= taken && hwrite;
			slotPh_q <= (haddr - SLOT_BASE) < SLOT_SPAN;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	chk_read_wait: assert property (
		taken && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read not answered after one wait state");
	chk_write_nowait: assert property (
		taken && hwrite |=> hreadyout)
		else $error("write phase stretched");
	chk_upper_zero: assert property (
		rdPh_q && hreadyout && slotPh_q |-> hrdata[31:8] == '0)
		else $error("slot read upper bits not zero");
	chk_rx_ready: assert property (
		arrive |=> dataReadyFlag)
		else $error("data ready missing after arrival");
	chk_overrun_set: assert property (
		arrive && !fifoEnable && dataReadyFlag && !(rdPh_q && !hreadyout) |=> overrunFlag)
		else $error("overwrite without overrun");
	chk_tx_load: assert property (
		slotWr && !fifoEnable |=> txAvail && txChar == $past(hwdata[7:0]))
		else $error("holding not loaded by slot write");
	chk_fifo_accept: assert property (
		slotWr && fifoEnable && txHoldingEmpty |=> !txHoldingEmpty)
		else $error("fifo write not accepted");
	chk_tx_drain: assert property (
		ce && txTake && txAvail && !fifoEnable && !(wrPh_q && hready) |=> txHoldingEmpty)
		else $error("holding empty not restored");
	chk_hold_pending: assert property (
		!fifoEnable && !txHoldingEmpty && !txTake && !(wrPh_q && hready) |=> !txHoldingEmpty)
		else $error("pending character lost without a take");
endmodule
bind uart_shadow_data_port uart_shadow_data_port_sva uart_shadow_data_port_sva_inst (
	.clk(clk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
	.rxSerialValid(rxSerialValid), .rxInfraValid(rxInfraValid), .txAvail(txAvail),
	.txChar(txChar), .txTake(txTake), .txInfraSel(txInfraSel), .dataReadyFlag(dataReadyFlag),
	.overrunFlag(overrunFlag), .txHoldingEmpty(txHoldingEmpty), .fifoEnable(fifoEnable));

/* File: sim/uart_peer_model.sv */
`timescale 1ns/1ps
module uart_peer_model (
	input  wire logic                               clk,
	input  wire logic                               nrst,
	input  wire logic                               hold,
	input  wire logic                               txAvail,
	input  wire logic [uart_shadow_pkg::CHAR_W-1:0] txChar,
	output logic                                    txTake,
	output logic                                    rxSerialValid,
	output logic [uart_shadow_pkg::CHAR_W-1:0]      rxSerialChar,
	output logic                                    rxInfraValid,
	output logic [uart_shadow_pkg::CHAR_W-1:0]      rxInfraChar
);
	import uart_shadow_pkg::*;
	logic              req      = 1'b0;
	logic              reqInfra = 1'b0;
	logic [CHAR_W-1:0] reqChar  = 8'h00;
	// idle lanes keep moving so a stale character never looks fresh
	always @(posedge clk) begin
		if (!nrst) begin
			txTake        <= 1'b0;
			rxSerialValid <= 1'b0;
			rxInfraValid  <= 1'b0;
			rxSerialChar  <= 8'h5a;
			rxInfraChar   <= 8'ha5;
		end else begin
			rxSerialValid <= req && !reqInfra;
			rxInfraValid  <= req && reqInfra;
			rxSerialChar  <= (req && !reqInfra) ? reqChar : ~rxSerialChar;
			rxInfraChar   <= (req && reqInfra) ? reqChar : rxInfraChar + 8'h01;
			txTake        <= txAvail && !txTake && !hold;
		end
	end
	task automatic send(input logic [7:0] c, input logic infra);
		@(negedge clk);
		reqChar = c;
		reqInfra = infra;
		req = 1'b1;
		@(negedge clk);
		req = 1'b0;
		@(posedge clk);
	endtask
endmodule

/* File: sim/tb.sv */
`timescale 1ns/1ps
module tb;
	import uart_shadow_pkg::*;
	logic        clk, nrst, ce, hsel, hwrite, hready, hreadyout, hresp, hold;
	logic        dataPh = 1'b0;
	logic        dataRd = 1'b0;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata;
	logic        rxSerialValid, rxInfraValid, txAvail, txTake, txInfraSel, irq;
	logic        dataReadyFlag, overrunFlag, txHoldingEmpty, fifoEnable;
	logic [7:0]  rxSerialChar, rxInfraChar, txChar;
	logic [7:0]  ch[17];
	logic [31:0] rdQ[$];
	logic [7:0]  txQ[$];
	int          mismatches = 0, tests_run = 0, cycles = 0;
	assign hready = hreadyout;
	uart_shadow_data_port uart_shadow_data_port_inst (.clk(clk), .nrst(nrst), .ce(ce), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.rxSerialValid(rxSerialValid), .rxSerialChar(rxSerialChar), .rxInfraValid(rxInfraValid),
		.rxInfraChar(rxInfraChar), .txAvail(txAvail), .txChar(txChar), .txTake(txTake),
		.txInfraSel(txInfraSel), .dataReadyFlag(dataReadyFlag), .overrunFlag(overrunFlag),
		.txHoldingEmpty(txHoldingEmpty), .fifoEnable(fifoEnable), .irq(irq));
	uart_peer_model uart_peer_model_inst (.clk(clk), .nrst(nrst), .hold(hold), .txAvail(txAvail),
		.txChar(txChar), .txTake(txTake), .rxSerialValid(rxSerialValid),
		.rxSerialChar(rxSerialChar), .rxInfraValid(rxInfraValid), .rxInfraChar(rxInfraChar));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic flag(input string what, input logic seen, input logic exp);
		check(what, {31'h0, seen}, {31'h0, exp});
	endtask
	task automatic final_report();
		$display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	function automatic logic [31:0] slot();
		return SLOT_BASE + 32'($urandom_range(15) * 4);
	endfunction
	task automatic bus(input logic [31:0] a, input logic wr, input logic [31:0] d);
		@(posedge clk);
		if (!wr) begin
			rdQ.push_back(d);
		end
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= a;
		hwrite <= wr;
		do @(posedge clk); while (!hreadyout);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (!hreadyout);
	endtask
	task automatic waitEmpty();
		for (int i = 0; i < 100 && txHoldingEmpty !== 1'b1; i++) begin
			@(negedge clk);
		end
		check("tx left over", 32'(txQ.size()), 32'h0);
	endtask
	// notes are matched against results in order of arrival
	always @(posedge clk) begin
		if (dataPh && dataRd && hreadyout) begin
			check("hrdata", hrdata, rdQ.pop_front());
		end
		if (dataPh && hreadyout) begin
			flag("hresp", hresp, 1'b0);
		end
		if (txTake && txAvail) begin
			check("txChar", {24'h0, txChar}, {24'h0, txQ.pop_front()});
		end
		if (hreadyout) begin
			dataPh <= hsel && htrans[1];
			dataRd <= !hwrite;
		end
		cycles <= cycles + 1;
		if (cycles > 5000) begin
			mismatches++;
			final_report();
		end
	end
	initial begin
		void'($urandom(58));
		{nrst, hsel, hwrite, hold, htrans} = '0;
		ce = 1'b1;
		hsize = 3'b010;
		haddr = 32'h0;
		hwdata = 32'h0;
		foreach (ch[i]) ch[i] = 8'($urandom);
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		flag("empty at reset", txHoldingEmpty, 1'b1);
		bus(SLOT_BASE + SLOT_SPAN, 1'b0, 32'h0);
		bus(LINE_STATUS_ADDR, 1'b0, 32'h60);
		bus(IRQ_MASK_ADDR, 1'b1, 32'h1);
		uart_peer_model_inst.send(ch[0], 1'b0);
		@(negedge clk);
		flag("irq raised", irq, 1'b1);
		bus(IRQ_MASK_ADDR, 1'b1, 32'h0);
		@(negedge clk);
		flag("irq masked", irq, 1'b0);
		bus(IRQ_MASK_ADDR, 1'b1, 32'h1);
		bus(IRQ_STATUS_ADDR, 1'b0, 32'h1);
		@(negedge clk);
		flag("irq cleared", irq, 1'b0);
		bus(IRQ_MASK_ADDR, 1'b1, 32'h0);
		bus(slot(), 1'b0, {24'h0, ch[0]});
		uart_peer_model_inst.send(ch[1], 1'b0);
		uart_peer_model_inst.send(ch[2], 1'b0);
		@(negedge clk);
		flag("ready pin", dataReadyFlag, 1'b1);
		flag("overrun pin", overrunFlag, 1'b1);
		bus(LINE_STATUS_ADDR, 1'b0, 32'h63);
		bus(slot(), 1'b0, {24'h0, ch[2]});
		bus(LINE_STATUS_ADDR, 1'b0, 32'h60);
		bus(MODE_CTRL_ADDR, 1'b1, 32'h1);
		uart_peer_model_inst.send(ch[3], 1'b1);
		uart_peer_model_inst.send(ch[4], 1'b0);
		bus(slot(), 1'b0, {24'h0, ch[3]});
		@(negedge clk);
		flag("infrared out", txInfraSel, 1'b1);
		bus(MODE_CTRL_ADDR, 1'b1, 32'h0);
		hold <= 1'b1;
		bus(slot(), 1'b1, {24'($urandom), ch[5]});
		@(negedge clk);
		flag("empty cleared", txHoldingEmpty, 1'b0);
		bus(slot(), 1'b1, {24'($urandom), ch[6]});
		txQ.push_back(ch[6]);
		hold <= 1'b0;
		waitEmpty();
		bus(FIFO_CTRL_ADDR, 1'b1, 32'h1);
		@(negedge clk);
		flag("fifo on", fifoEnable, 1'b1);
		for (int i = 0; i < 17; i++) uart_peer_model_inst.send(ch[i], 1'b0);
		bus(LINE_STATUS_ADDR, 1'b0, 32'h63);
		for (int i = 0; i < 16; i++) bus(slot(), 1'b0, {24'h0, ch[i]});
		bus(LINE_STATUS_ADDR, 1'b0, 32'h60);
		hold <= 1'b1;
		for (int i = 0; i < 17; i++) bus(slot(), 1'b1, {24'($urandom), ch[i]});
		for (int i = 0; i < 16; i++) txQ.push_back(ch[i]);
		hold <= 1'b0;
		waitEmpty();
		uart_peer_model_inst.send(ch[7], 1'b0);
		bus(LINE_STATUS_ADDR, 1'b0, 32'h61);
		bus(FIFO_CTRL_ADDR, 1'b1, 32'h3);
		bus(LINE_STATUS_ADDR, 1'b0, 32'h60);
		ce <= 1'b0;
		uart_peer_model_inst.send(ch[8], 1'b0);
		ce <= 1'b1;
		bus(LINE_STATUS_ADDR, 1'b0, 32'h60);
		bus(IRQ_STATUS_ADDR, 1'b0, 32'hf);
		bus(IRQ_STATUS_ADDR, 1'b0, 32'h0);
		final_report();
	end
endmodule
